// ---- include/eps_params.svh ----
`ifndef EPS_PARAMS_SVH
`define EPS_PARAMS_SVH

// ----------------------------------------
// Serial port constants
// ----------------------------------------
`define EPS_BYTE_W 8
`define EPS_FIFO_DEPTH 4
`define EPS_CNT_W 4
`define EPS_LAST_BIT_4W 4'h7
`define EPS_LAST_BIT_3W 4'h8
`define EPS_PINS_RST 6'h08

`endif

// ---- include/eps_pkg.sv ----
`include "eps_params.svh"

package eps_pkg;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    // Pin group as sampled from the host side
    typedef struct packed {
        logic reset_n;
        logic strap;
        logic cs_n;
        logic sclk;
        logic sda;
        logic dc;
    } eps_pins_type;

    // Received byte with its command/data flag
    typedef struct packed {
        logic is_data;
        logic [`EPS_BYTE_W-1:0] value;
    } eps_rx_type;

    // Port phase within one selection
    typedef enum logic [1:0] {
        PH_RECEIVE,
        PH_ARMED,
        PH_READ
    } eps_phase_type;

endpackage

// ---- verilog/eps_fifo.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// Shift-style FIFO, head always in entry 0
// ----------------------------------------
module eps_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clr_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    logic [WIDTH-1:0] mem_q [DEPTH]; // Entries, head at 0
    logic [DEPTH-1:0] occ_q; // Entry occupied flags
    logic [DEPTH:0] occ_pad; // Occupancy with empty slot above
    logic [DEPTH-1:0] sh_occ; // Occupancy after a pop shift
    logic [DEPTH:0] sh_pad; // Shifted occupancy, full slot below
    logic pop;
    logic push;

    assign pop = occ_q[0] & out_ready_in;
    assign push = in_valid_in & ~occ_q[DEPTH-1];
    assign occ_pad = {1'b0, occ_q};
    assign sh_pad = {sh_occ, 1'b1};
    assign in_ready_out = ~occ_q[DEPTH-1];
    assign out_valid_out = occ_q[0];
    assign out_data_out = mem_q[0];

    genvar i;
    for (i = 0; i < DEPTH; i++)
    begin : g_entry
        logic take; // Incoming word lands here
        logic [WIDTH-1:0] upper; // Word from the entry above, own word for the top entry
        assign sh_occ[i] = pop ? occ_pad[i+1] : occ_q[i];
        assign take = push & ~sh_occ[i] & sh_pad[i];
        if (i == DEPTH-1)
        begin : g_top
            assign upper = mem_q[i];
        end
        else
        begin : g_mid
            assign upper = mem_q[i+1];
        end

        // Occupancy of this entry
        always_ff @(posedge clk_in or negedge rst_n_in)
        begin
            if (!rst_n_in)
                occ_q[i] <= 1'b0;
            else if (clr_in)
                occ_q[i] <= 1'b0;
            else
                occ_q[i] <= sh_occ[i] | take;
        end

        // Data of this entry
        always_ff @(posedge clk_in or negedge rst_n_in)
        begin
            if (!rst_n_in)
                mem_q[i] <= '0;
            else if (take)
                mem_q[i] <= in_data_in;
            else if (pop)
                mem_q[i] <= upper;
        end
    end
endmodule // eps_fifo

// ---- verilog/eps_port.sv ----
`timescale 1ns/1ps
// Summary of operation
// R1: Transfers only while chip select low
// R2: 4-wire: select high data, low command
// R3: Active-low reset pin returns port to initial
// R4: Busy high during waveform or sensor work
// R5: Host issues nothing while busy high
// R6: Strap low 4-wire, strap high 3-wire
// R7: 4-wire write sampled on rising, MSB first
// R8: Host holds select constant through byte
// R9: Byte delivered as data or command
// R10: Host sends read identifier, select low
// R11: Host raises select before read data
// R12: Read bytes driven on falling edges, MSB first
// R13: Read bytes continue until chip select rises
// R14: 3-wire: flag bit then eight bits
// R15: 3-wire: host ties select low
// R16: 3-wire read: flag one before read bytes
// R17: Deselect clears bit counter and partial byte
// R18: Data line released outside read phase
`include "eps_params.svh"

module eps_port (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic reset_n_input_in,
    input wire logic interface_select_strap_in,
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic sda_in,
    input wire logic dc_sel_in,
    output logic sda_out_out,
    output logic sda_oe_out,
    input wire logic engine_busy_in,
    output logic busy_out,
    output eps_pkg::eps_rx_type rx_data_out,
    output logic rx_valid_out,
    input wire logic rx_ready_in,
    output logic [`EPS_BYTE_W-1:0] cmd_id_out,
    input wire logic rd_enable_in,
    input wire logic [`EPS_BYTE_W-1:0] rd_data_in,
    output logic rd_take_out
);
    import eps_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    eps_pins_type pins_raw; // Pins as they arrive
    eps_pins_type meta_q; // First sync stage
    eps_pins_type sync_q; // Second sync stage
    logic sclk_prev_q; // Clock level one cycle back
    logic port_clr; // Reset pin asserted
    logic desel; // Chip select high
    logic rise; // Host clock rising while selected
    logic fall; // Host clock falling while selected
    logic mode_q; // 1 for 3-wire framing
    logic [`EPS_CNT_W-1:0] cnt_q; // Bit position in frame
    logic [`EPS_CNT_W-1:0] last_bit; // Final bit index for framing
    logic [`EPS_BYTE_W-1:0] sh_q; // Write shift register
    logic [`EPS_BYTE_W-1:0] sh_next; // Shift register with new bit
    logic flag_q; // 3-wire data/command flag
    logic last_cmd_q; // Previous byte was a command
    logic push_q; // Byte complete pulse
    eps_rx_type push_data_q; // Completed byte
    logic [`EPS_BYTE_W-1:0] cmd_id_q; // Latest command byte
    logic arm3; // 3-wire read flag arriving
    logic start_read; // Read phase begins on this fall
    eps_phase_type phase_q; // Phase within selection
    logic [`EPS_BYTE_W-1:0] out_sh_q; // Read byte being sent
    logic [2:0] out_cnt_q; // Read bit position
    logic next_bit; // Bit due on the next fall
    logic sda_out_q;
    logic sda_oe_q;
    logic take_q;
    logic busy_q;
    logic fifo_ready; // FIFO can take a byte

    assign pins_raw = '{reset_n: reset_n_input_in, strap: interface_select_strap_in, cs_n: cs_n_in,
                        sclk: sclk_in, sda: sda_in, dc: dc_sel_in};
    assign port_clr = ~sync_q.reset_n;
    assign desel = sync_q.cs_n;
    assign rise = sync_q.sclk & ~sclk_prev_q & ~desel & ~port_clr; // [R1]
    assign fall = ~sync_q.sclk & sclk_prev_q & ~desel & ~port_clr; // [R1]
    assign last_bit = mode_q ? `EPS_LAST_BIT_3W : `EPS_LAST_BIT_4W; // [R6]
    assign sh_next = {sh_q[`EPS_BYTE_W-2:0], sync_q.sda};
    assign arm3 = mode_q & (cnt_q == '0) & last_cmd_q & rd_enable_in & sync_q.sda; // [R16]
    assign start_read = fall & ((phase_q == PH_ARMED) |
        ((phase_q == PH_RECEIVE) & ~mode_q & (cnt_q == '0) & last_cmd_q & rd_enable_in));
    assign next_bit = out_sh_q[3'h7 - out_cnt_q];

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Two stages for every host pin
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_q <= `EPS_PINS_RST;
            sync_q <= `EPS_PINS_RST;
        end
        else
        begin
            meta_q <= pins_raw;
            sync_q <= meta_q;
        end
    end

    // Host clock history for edge finding
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            sclk_prev_q <= 1'b0;
        else
            sclk_prev_q <= sync_q.sclk;
    end

    // ----------------------------------------
    // Framing select
    // ----------------------------------------
    // Strap followed only between selections
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            mode_q <= 1'b0;
        else if (desel)
            mode_q <= sync_q.strap; // [R6]
    end

    // ----------------------------------------
    // Write receiver
    // ----------------------------------------
    // Bit counter and shift register
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cnt_q <= '0;
            sh_q <= '0;
            flag_q <= 1'b0;
        end
        else if (port_clr | desel)
        begin
            cnt_q <= '0; // [R3] [R17]
            sh_q <= '0;
        end
        else if (rise & (phase_q == PH_RECEIVE) & ~arm3)
        begin
            if (mode_q & (cnt_q == '0))
                flag_q <= sync_q.sda; // [R14]
            else
                sh_q <= sh_next; // [R7] [R14]
            cnt_q <= (cnt_q == last_bit) ? '0 : cnt_q + 1'b1;
        end
    end

    // Byte completion and delivery
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            push_q <= 1'b0;
            push_data_q <= '0;
            last_cmd_q <= 1'b0;
            cmd_id_q <= '0;
        end
        else
        begin
            push_q <= 1'b0;
            if (port_clr | desel)
                last_cmd_q <= 1'b0;
            else if (rise & (phase_q == PH_RECEIVE) & ~arm3 & (cnt_q == last_bit))
            begin
                push_q <= 1'b1;
                // Flag from the frame or from the select pin
                push_data_q <= '{is_data: mode_q ? flag_q : sync_q.dc, value: sh_next}; // [R2] [R9]
                last_cmd_q <= ~(mode_q ? flag_q : sync_q.dc);
                if (!(mode_q ? flag_q : sync_q.dc))
                    cmd_id_q <= sh_next; // [R9]
            end
        end
    end

    // ----------------------------------------
    // Phase control
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            phase_q <= PH_RECEIVE;
        else if (port_clr | desel)
            phase_q <= PH_RECEIVE; // [R3] [R13]
        else
        begin
            unique case (phase_q)
                PH_RECEIVE:
                begin
                    if (rise & arm3)
                        phase_q <= PH_ARMED; // [R16]
                    else if (start_read)
                        phase_q <= PH_READ;
                end
                PH_ARMED:
                begin
                    if (fall)
                        phase_q <= PH_READ;
                end
                PH_READ:
                    phase_q <= PH_READ;
            endcase
        end
    end

    // ----------------------------------------
    // Read transmitter
    // ----------------------------------------
    // New bit on each fall, next byte after eight
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            out_sh_q <= '0;
            out_cnt_q <= '0;
            sda_out_q <= 1'b0;
            sda_oe_q <= 1'b0;
            take_q <= 1'b0;
        end
        else
        begin
            take_q <= 1'b0;
            if (port_clr | desel)
            begin
                out_cnt_q <= '0;
                sda_out_q <= 1'b0;
                sda_oe_q <= 1'b0; // [R18]
            end
            else if (start_read | (fall & (phase_q == PH_READ)))
            begin
                sda_oe_q <= 1'b1; // [R18]
                out_cnt_q <= out_cnt_q + 1'b1;
                if (out_cnt_q == 3'h0)
                begin
                    out_sh_q <= rd_data_in; // [R13]
                    sda_out_q <= rd_data_in[`EPS_BYTE_W-1]; // [R12]
                    take_q <= 1'b1;
                end
                else
                    sda_out_q <= next_bit; // [R12]
            end
        end
    end

    // ----------------------------------------
    // Busy and buffering
    // ----------------------------------------
    // Busy also covers a full receive buffer
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            busy_q <= 1'b0;
        else
            busy_q <= engine_busy_in | ~fifo_ready; // [R4]
    end

    eps_fifo #(
        .WIDTH($bits(eps_rx_type)),
        .DEPTH(`EPS_FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .clr_in(port_clr),
        .in_valid_in(push_q),
        .in_data_in(push_data_q),
        .in_ready_out(fifo_ready),
        .out_valid_out(rx_valid_out),
        .out_data_out(rx_data_out),
        .out_ready_in(rx_ready_in)
    );

    assign sda_out_out = sda_out_q;
    assign sda_oe_out = sda_oe_q;
    assign busy_out = busy_q;
    assign cmd_id_out = cmd_id_q;
    assign rd_take_out = take_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    AST_R1_NO_BYTE_DESELECTED: assert property (desel |=> !push_q) // [R1]
        else $error("byte completed while deselected");
    AST_R2_SELECT_PIN_FLAG: assert property ((rise && !mode_q && phase_q == PH_RECEIVE && cnt_q == 4'h7)
        |=> push_q && push_data_q.is_data == $past(sync_q.dc)) // [R2]
        else $error("4-wire flag does not follow select pin");
    AST_R3_PIN_RESET: assert property (port_clr |=> cnt_q == '0 && phase_q == PH_RECEIVE && !sda_oe_out) // [R3]
        else $error("reset pin did not restore port");
    AST_R4_BUSY: assert property (engine_busy_in |=> busy_out) // [R4]
        else $error("busy not raised");
    AST_R6_MODE: assert property (desel |=> mode_q == $past(sync_q.strap)) // [R6]
        else $error("framing does not follow strap");
    AST_R7_SHIFT: assert property ((rise && !mode_q && phase_q == PH_RECEIVE) // [R7]
        |=> sh_q[0] == $past(sync_q.sda))
        else $error("write bit not shifted in");
    AST_R9_COMMAND_KEPT: assert property ((push_q && !push_data_q.is_data) // [R9]
        |-> cmd_id_out == push_data_q.value)
        else $error("command byte not delivered");
    AST_R12_READ_BIT: assert property ((fall && phase_q == PH_READ && out_cnt_q != 3'h0)
        |=> sda_out_out == $past(next_bit)) // [R12]
        else $error("read bit out of order");
    AST_R13_NEXT_BYTE: assert property ((fall && phase_q == PH_READ && out_cnt_q == 3'h0) |=> rd_take_out) // [R13]
        else $error("next read byte not taken");
    AST_R14_FLAG_BIT: assert property ((push_q && mode_q) |-> push_data_q.is_data == flag_q) // [R14]
        else $error("3-wire flag lost");
    AST_R16_ARM: assert property ((rise && phase_q == PH_RECEIVE && arm3) |=> phase_q == PH_ARMED) // [R16]
        else $error("read flag not seen");
    AST_R17_CLEAR: assert property (desel |=> cnt_q == '0 ##1 cnt_q == '0 || !desel) // [R17]
        else $error("counter kept across deselect");
    // Enable is registered, so it may still stand in the first deselected cycle
    AST_R18_RELEASE: assert property (sda_oe_out |-> phase_q == PH_READ && !$past(desel)) // [R18]
        else $error("data line driven outside read");
    AST_R18_DESEL_RELEASE: assert property (desel |=> !sda_oe_out) // [R18]
        else $error("data line kept after deselect");
endmodule // eps_port

// ---- verification/eps_host_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// Host serial master model
// ----------------------------------------
module eps_host_model (
    input wire logic clk_in,
    output logic cs_n_out,
    output logic sclk_out,
    output logic sda_drv_out,
    output logic dc_out,
    output logic strap_out,
    input wire logic sda_line_in,
    input wire logic busy_in
);
    localparam int HALF = 80; // Half of the 160 ns link period
    logic [7:0] rd_q[$]; // Bytes read back

    // Pins idle: deselected, clock low
    initial
    begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        sda_drv_out = 1'b0;
        dc_out = 1'b0;
        strap_out = 1'b0;
    end

    // Low n bits, MSB first, data set while clock low
    task automatic shift(input int n, input logic [8:0] v);
        for (int i = n - 1; i >= 0; i--)
        begin
            sda_drv_out = v[i];
            #HALF sclk_out = 1'b1;
            #HALF sclk_out = 1'b0;
        end
    endtask

    // Deselect after the last fall
    task automatic close();
        #HALF cs_n_out = 1'b1;
        dc_out = 1'b0;
        #HALF;
    endtask

    // One selection; keep leaves chip select low
    task automatic frame(input logic three, input logic [8:0] v, input int n, input logic keep);
        wait (!busy_in);
        // Pin changes land just after a system clock edge
        @(posedge clk_in);
        #1 strap_out = three;
        #HALF cs_n_out = 1'b0;
        dc_out = three ? 1'b0 : v[8];
        shift(n, v);
        if (!keep)
            close();
    endtask

    // Register read; line released, so a toggling pattern stands in
    task automatic read(input logic three, input logic [7:0] id, input int nb);
        logic [7:0] b;
        frame(three, {1'b0, id}, three ? 9 : 8, 1'b1);
        if (three)
            shift(1, 9'h001);
        else
            dc_out = 1'b1;
        b = 8'h00;
        for (int i = 0; i < nb * 8; i++)
        begin
            sda_drv_out = ~sda_drv_out;
            #HALF sclk_out = 1'b1;
            b = {b[6:0], sda_line_in};
            if (i % 8 == 7)
                rd_q.push_back(b);
            #HALF sclk_out = 1'b0;
        end
        close();
    endtask
endmodule // eps_host_model

// ---- verification/eps_port_tb.sv ----
`timescale 1ns/1ps
`include "eps_params.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; $display("BAD %s exp %h got %h", nm, e, g); end end

module eps_port_tb;
    import eps_pkg::*;
    localparam logic [7:0] RD_ID = 8'h2f; // Readable register id
    localparam logic [7:0] RD_BASE = 8'ha5; // First read byte
    logic clk_in = 1'b0, rst_n_in = 1'b0, reset_n_input_in = 1'b1, engine_busy_in = 1'b0;
    logic rx_ready_in = 1'b0, rd_enable_in = 1'b0, hold = 1'b0, rd_win = 1'b0;
    logic [7:0] rd_data_in = 8'h00, cmd_id, last_cmd = 8'h00;
    logic cs_n, sclk, sda_drv, dc, strap, sda_out, sda_oe, busy, rx_valid, rd_take;
    eps_rx_type rx_data;
    eps_rx_type exp_q[$], got_q[$];
    wire sda_line = sda_oe ? sda_out : sda_drv; // Shared data wire
    int fails = 0, n_tests = 0, oe_bad = 0;
    logic [31:0] seed = 32'h92c;

    always #5 clk_in = ~clk_in;

    eps_port dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .reset_n_input_in(reset_n_input_in),
        .interface_select_strap_in(strap), .cs_n_in(cs_n), .sclk_in(sclk), .sda_in(sda_line),
        .dc_sel_in(dc), .sda_out_out(sda_out), .sda_oe_out(sda_oe), .engine_busy_in(engine_busy_in),
        .busy_out(busy), .rx_data_out(rx_data), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready_in),
        .cmd_id_out(cmd_id), .rd_enable_in(rd_enable_in), .rd_data_in(rd_data_in), .rd_take_out(rd_take));

    eps_host_model host (.clk_in(clk_in), .cs_n_out(cs_n), .sclk_out(sclk), .sda_drv_out(sda_drv), .dc_out(dc),
        .strap_out(strap), .sda_line_in(sda_line), .busy_in(busy));

    // Xorshift source
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected received entry
    function automatic eps_rx_type mk(input logic d, input logic [7:0] v);
        return '{is_data: d, value: v};
    endfunction

    // Consumer with random stalls, decoder stand-in, stray drive watch
    always @(posedge clk_in)
    begin
        rx_ready_in <= #1 !hold && ((xs() & 32'h1) != 32'h0);
        if (rx_valid === 1'b1 && rx_ready_in)
            got_q.push_back(rx_data);
        rd_enable_in <= #1 (cmd_id === RD_ID);
        if (rd_take === 1'b1)
            rd_data_in <= #1 rd_data_in + 8'h01;
        if (sda_oe === 1'b1 && !rd_win)
            oe_bad++;
    end

    // ----
    // Tasks
    // ----
    // One whole write byte
    task automatic wr(input logic three, input logic d, input logic [7:0] v);
        host.frame(three, {d, v}, three ? 9 : 8, 1'b0);
        exp_q.push_back(mk(d, v));
        if (!d)
            last_cmd = v;
    endtask

    // Compare all drained bytes and last command
    task automatic check_rx();
        repeat (40) @(posedge clk_in);
        #1;
        `CHK("count", exp_q.size(), got_q.size())
        foreach (exp_q[i]) if (i < got_q.size()) `CHK("rx", exp_q[i], got_q[i])
        `CHK("cmd", last_cmd, cmd_id)
        exp_q = {};
        got_q = {};
    endtask

    // Register read of nb bytes
    task automatic rd(input logic three, input int nb);
        @(posedge clk_in);
        #1 rd_data_in = RD_BASE;
        rd_win = 1'b1;
        host.read(three, RD_ID, nb);
        exp_q.push_back(mk(1'b0, RD_ID));
        last_cmd = RD_ID;
        repeat (10) @(posedge clk_in);
        #1 rd_win = 1'b0;
        `CHK("nrd", nb, host.rd_q.size())
        foreach (host.rd_q[k]) `CHK("rd", RD_BASE + 8'(k), host.rd_q[k])
        `CHK("oe", 1'b0, sda_oe)
        host.rd_q = {};
    endtask

    // Verdict
    task automatic end_sim();
        `CHK("oe_stray", 0, oe_bad)
        $display("fails %0d n_tests %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        #500000;
        fails++;
        end_sim();
    end

    // Main sequence
    initial
    begin
        logic [31:0] r;
        repeat (16) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
        repeat (10) @(posedge clk_in);
        // Random writes, both framings, edge values first
        for (int m = 0; m < 2; m++)
        begin
            for (int i = 0; i < 12; i++)
            begin
                r = xs();
                wr(m == 1, r[8], i == 0 ? 8'hff : i == 1 ? 8'h00 : (r[7:0] == RD_ID ? 8'h11 : r[7:0]));
            end
            check_rx();
        end
        // Clock activity while deselected
        host.shift(9, 9'h155);
        check_rx();
        // Partial bytes dropped at deselect
        host.frame(1'b0, 9'h0c3, 3, 1'b0);
        wr(1'b0, 1'b1, 8'h3c);
        host.frame(1'b1, 9'h1f0, 5, 1'b0);
        wr(1'b1, 1'b0, 8'hc5);
        check_rx();
        // Engine activity shows on busy
        @(posedge clk_in);
        #1 engine_busy_in = 1'b1;
        @(posedge clk_in);
        #1 `CHK("busy", 1'b1, busy)
        engine_busy_in = 1'b0;
        @(posedge clk_in);
        #1 `CHK("busy", 1'b0, busy)
        // Fill the buffer while stalled, then drain
        hold = 1'b1;
        for (int i = 0; i < `EPS_FIFO_DEPTH; i++)
            wr(1'b0, 1'b1, 8'(8'h40 + i));
        repeat (10) @(posedge clk_in);
        #1 `CHK("full", 1'b1, busy)
        hold = 1'b0;
        check_rx();
        `CHK("busy", 1'b0, busy)
        // Reset pin clears a held byte
        hold = 1'b1;
        wr(1'b0, 1'b1, 8'h5a);
        @(posedge clk_in);
        #1 reset_n_input_in = 1'b0;
        repeat (5) @(posedge clk_in);
        #1 reset_n_input_in = 1'b1;
        repeat (10) @(posedge clk_in);
        `CHK("rst", 1'b0, rx_valid)
        hold = 1'b0;
        exp_q = {};
        // Reads in both framings
        rd(1'b0, 3);
        rd(1'b1, 2);
        wr(1'b0, 1'b1, 8'h96);
        check_rx();
        end_sim();
    end
endmodule // eps_port_tb
